// ### hdl/uafc_pkg.sv
// Shared constants and types of the uplink frequency-control pin driver
package uafc_pkg;

    // ********************************************************************
    // Connector and codes
    // ********************************************************************
    localparam int          PINS      = 25;
    localparam int          FREQ_BITS = 24;
    localparam logic [4:0]  CODE_GND  = 5'h1F;
    localparam logic [4:0]  CODE_HIGH = 5'h1E;
    localparam logic [4:0]  CODE_IN   = 5'h1D;
    localparam logic [4:0]  CODE_OFF  = 5'h1C;

    // ********************************************************************
    // Uplink frame layout and timing
    // ********************************************************************
    localparam int          FRAME_BITS        = 40;
    localparam logic [3:0]  KIND_FREQ         = 4'h1;
    localparam logic [3:0]  KIND_MAP          = 4'h2;
    localparam logic [3:0]  KIND_CFG          = 4'h3;
    localparam int          CFG_INV_POS       = 16;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          UPL_BIT_CLKS_FULL = 8;
    localparam int          VALID_HOLD_NS     = 1_000_000;
    localparam int          VALID_HOLD_CYC    = VALID_HOLD_NS / CLK_PERIOD_NS;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [11:0] REG_STATUS   = 12'h000;
    localparam logic [11:0] REG_FREQ     = 12'h004;
    localparam logic [11:0] REG_INT_STAT = 12'h008;
    localparam logic [11:0] REG_INT_MASK = 12'h00C;
    localparam logic [11:0] REG_FAULT    = 12'h010;
    localparam int          ST_VALID_POS = 0;
    localparam int          ST_FAULT_POS = 1;
    localparam int          ST_MODE_POS  = 2;
    localparam int          ST_RATIO_POS = 4;
    localparam int          INT_W        = 4;
    localparam int          INT_OK_POS   = 0;
    localparam int          INT_ERR_POS  = 1;
    localparam int          INT_FLT_POS  = 2;
    localparam int          INT_LOST_POS = 3;
    localparam logic [3:0]  INT_MASK_RST = 4'h0;

    typedef enum logic [1:0] {
        MODE_LOW_PINS,
        MODE_HIGH_PINS,
        MODE_SCRAMBLED,
        MODE_PINMAP
    } uafc_mode_type;

endpackage : uafc_pkg

// ### hdl/uafc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module uafc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    if (WIDTH < 1)
    begin : g_bad
        $error("uafc_sync: WIDTH must be positive");
    end

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : uafc_sync

// ### hdl/uafc_uplink_rx.sv
// Serial uplink frame receiver with stop and checksum checks
`timescale 1ns/10ps
module uafc_uplink_rx
    import uafc_pkg::*;
#(
    parameter int BIT_CLKS_FULL = uafc_pkg::UPL_BIT_CLKS_FULL
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        line_in,
    input  wire logic        slow_clock,
    output logic             frame_ok,
    output logic             frame_err,
    output logic [39:0]      frame_data
);
    localparam int BIT_CLKS_SLOW = (BIT_CLKS_FULL * 3) / 4;

    if (BIT_CLKS_FULL < 4 || BIT_CLKS_FULL > 31 || FRAME_BITS != 40)
    begin : g_bad
        $error("uafc_uplink_rx: unsupported bit period or frame size");
    end

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        uafc_rx_state_type;

    uafc_rx_state_type state_q, state_d;
    logic [4:0]        cnt_q, cnt_d;
    logic [5:0]        bits_q, bits_d;
    logic [39:0]       shift_q, shift_d, data_q, data_d;
    logic              ok_q, ok_d, err_q, err_d;
    logic [4:0]        period;
    logic              sum_good;

    always_comb
    begin
        // Bit period follows the local crystal choice
        period = slow_clock ? 5'(BIT_CLKS_SLOW) : 5'(BIT_CLKS_FULL);
        sum_good = (shift_q[39:32] ^ shift_q[31:24] ^ shift_q[23:16]
                    ^ shift_q[15:8]) == shift_q[7:0];
        state_d = state_q;
        cnt_d   = cnt_q;
        bits_d  = bits_q;
        shift_d = shift_q;
        data_d  = data_q;
        ok_d    = 1'b0;
        err_d   = 1'b0;
        unique case (state_q)
            RX_IDLE:
            begin
                if (!line_in)
                begin
                    state_d = RX_START;
                    cnt_d   = period >> 1;
                end
            end
            RX_START:
            begin
                if (cnt_q != 5'h0_0)
                    cnt_d = cnt_q - 5'h0_1;
                else if (!line_in)
                begin
                    state_d = RX_DATA;
                    cnt_d   = period - 5'h0_1;
                    bits_d  = 6'h0_0;
                end
                else
                    state_d = RX_IDLE;
            end
            RX_DATA:
            begin
                if (cnt_q != 5'h0_0)
                    cnt_d = cnt_q - 5'h0_1;
                else
                begin
                    shift_d = {shift_q[38:0], line_in};
                    cnt_d   = period - 5'h0_1;
                    bits_d  = bits_q + 6'h0_1;
                    if (bits_q == 6'(FRAME_BITS - 1))
                        state_d = RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (cnt_q != 5'h0_0)
                    cnt_d = cnt_q - 5'h0_1;
                else
                begin
                    state_d = RX_IDLE;
                    // Corrupt frames never reach the stored data
                    if (line_in && sum_good)
                    begin
                        data_d = shift_q;
                        ok_d   = 1'b1;
                    end
                    else
                        err_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= RX_IDLE;
            cnt_q   <= '0;
            bits_q  <= '0;
            shift_q <= '0;
            data_q  <= '0;
            ok_q    <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            bits_q  <= bits_d;
            shift_q <= shift_d;
            data_q  <= data_d;
            ok_q    <= ok_d;
            err_q   <= err_d;
        end
    end

    assign frame_ok   = ok_q;
    assign frame_err  = err_q;
    assign frame_data = data_q;
endmodule : uafc_uplink_rx

// ### hdl/uafc_pin_driver.sv
// Uplink listener driving frequency-control pins, fault relay, APB slave
`timescale 1ns/10ps
module uafc_pin_driver
    import uafc_pkg::*;
#(
    parameter int VALID_HOLD    = uafc_pkg::VALID_HOLD_CYC,
    parameter int BIT_CLKS_FULL = uafc_pkg::UPL_BIT_CLKS_FULL
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  uplink_in,
    input  wire logic                  clock_ratio_jumper,
    input  wire logic                  protocol_select_low_jumper,
    input  wire logic                  protocol_select_high_jumper,
    input  wire logic [uafc_pkg::PINS-1:0] pin_in,
    output logic      [uafc_pkg::PINS-1:0] pin_out,
    output logic      [uafc_pkg::PINS-1:0] pin_oe,
    output logic                       fault_term_out,
    output logic                       fault_led,
    output logic                       uplink_valid_led,
    output logic                       irq,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr
);
    import uafc_pkg::*;

    localparam int VW = $clog2(VALID_HOLD + 1);

    if (VALID_HOLD < 2)
    begin : g_bad
        $error("uafc_pin_driver: VALID_HOLD must be at least 2");
    end

    // ********************************************************************
    // Input synchronisers and receiver
    // ********************************************************************
    logic [PINS-1:0] pin_s;
    logic            line_s, ratio_s, sel_lo_s, sel_hi_s;
    logic            rx_ok, rx_err;
    logic [39:0]     rx_data;

    uafc_sync #(.WIDTH(PINS + 4)) u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in ({pin_in, uplink_in, clock_ratio_jumper,
                    protocol_select_low_jumper,
                    protocol_select_high_jumper}),
        .sync_out ({pin_s, line_s, ratio_s, sel_lo_s, sel_hi_s})
    );

    // Listen only: the uplink is an input and nothing drives it back
    uafc_uplink_rx #(.BIT_CLKS_FULL(BIT_CLKS_FULL)) u_rx (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .line_in    (line_s),
        .slow_clock (ratio_s),
        .frame_ok   (rx_ok),
        .frame_err  (rx_err),
        .frame_data (rx_data)
    );

    // ********************************************************************
    // Mode decode and pin tables
    // ********************************************************************
    uafc_mode_type mode;

    always_comb
    begin
        unique case ({sel_hi_s, sel_lo_s})
            2'b11:   mode = MODE_LOW_PINS;
            2'b10:   mode = MODE_HIGH_PINS;
            2'b01:   mode = MODE_SCRAMBLED;
            default: mode = MODE_PINMAP;
        endcase
    end

    function automatic logic [4:0] fixed_code(uafc_mode_type m, int pin);
        logic [4:0] c;
        c = CODE_OFF;
        unique case (m)
            MODE_LOW_PINS:
                if (pin <= 16) c = 5'(pin - 1);
            MODE_HIGH_PINS:
                if (pin >= 10) c = 5'(25 - pin);
            MODE_SCRAMBLED:
            begin
                unique case (pin)
                    18: c = 5'h0_0;
                    19: c = 5'h0_1;
                    6:  c = 5'h0_2;
                    7:  c = 5'h0_3;
                    21: c = 5'h0_4;
                    22: c = 5'h0_5;
                    23: c = 5'h0_6;
                    11: c = 5'h0_7;
                    10: c = 5'h0_8;
                    9:  c = 5'h0_9;
                    20: c = 5'h0_A;
                    8:  c = 5'h0_B;
                    12: c = 5'h0_C;
                    25: c = 5'h0_D;
                    13: c = 5'h0_E;
                    24: c = 5'h0_F;
                    default: c = CODE_OFF;
                endcase
            end
            default: c = CODE_OFF;
        endcase
        return c;
    endfunction : fixed_code

    // ********************************************************************
    // Uplink-loaded state
    // ********************************************************************
    logic [FREQ_BITS-1:0] freq_q, freq_d;
    logic [4:0]           map_q [PINS];
    logic [4:0]           map_d [PINS];
    logic [4:0]           fpin_q, fpin_d;
    logic                 finv_q, finv_d;
    logic [3:0]           kind;

    assign kind = rx_data[39:36];

    always_comb
    begin
        freq_d = freq_q;
        map_d  = map_q;
        fpin_d = fpin_q;
        finv_d = finv_q;
        // Only checked frames update anything
        if (rx_ok)
        begin
            if (kind == KIND_FREQ)
                freq_d = rx_data[31:8];
            if (kind == KIND_MAP)
                for (int k = 0; k < 4; k++)
                    if (int'(rx_data[35:32]) * 4 + k < PINS)
                        map_d[int'(rx_data[35:32]) * 4 + k] =
                            rx_data[8 + 5 * k +: 5];
            if (kind == KIND_CFG)
            begin
                fpin_d = rx_data[12:8];
                finv_d = rx_data[CFG_INV_POS];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            freq_q <= '0;
            for (int i = 0; i < PINS; i++)
                map_q[i] <= CODE_GND;
            fpin_q <= '0;
            finv_q <= 1'b0;
        end
        else
        begin
            freq_q <= freq_d;
            map_q  <= map_d;
            fpin_q <= fpin_d;
            finv_q <= finv_d;
        end
    end

    // ********************************************************************
    // Pin drivers and fault relay
    // ********************************************************************
    logic [4:0]      fault_pin;
    logic            fault_raw;
    logic [PINS-1:0] out_d, oe_d, out_q, oe_q;
    logic            fault_q;

    always_comb
    begin
        unique case (mode)
            MODE_LOW_PINS:  fault_pin = 5'h1_9;
            MODE_HIGH_PINS: fault_pin = 5'h0_3;
            MODE_SCRAMBLED: fault_pin = 5'h0_4;
            default:        fault_pin = fpin_q;
        endcase
        fault_raw = 1'b0;
        if (fault_pin != 5'h0_0 && fault_pin <= 5'(PINS))
            fault_raw = pin_s[fault_pin - 5'h0_1] ^ finv_q;
    end

    for (genvar p = 0; p < PINS; p++)
    begin : g_pin
        logic [4:0] code;
        always_comb
        begin
            code = (mode == MODE_PINMAP) ? map_q[p] : fixed_code(mode, p + 1);
            out_d[p] = 1'b0;
            oe_d[p]  = 1'b1;
            // The fault pin is always released so it can be read
            if (fault_pin == 5'(p + 1) || code == CODE_IN || code == CODE_OFF)
                oe_d[p] = 1'b0;
            else if (code < 5'(FREQ_BITS))
                out_d[p] = freq_q[code];
            else if (code == CODE_HIGH)
                out_d[p] = 1'b1;
            else
                out_d[p] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_q   <= '0;
            oe_q    <= '0;
            fault_q <= 1'b0;
        end
        else
        begin
            out_q   <= out_d;
            oe_q    <= oe_d;
            fault_q <= fault_raw;
        end
    end

    assign pin_out        = out_q;
    assign pin_oe         = oe_q;
    assign fault_term_out = fault_q;
    assign fault_led      = fault_q;

    // ********************************************************************
    // Uplink valid timer
    // ********************************************************************
    logic [VW-1:0] vcnt_q, vcnt_d;
    logic          valid_q, valid_d;

    always_comb
    begin
        vcnt_d = vcnt_q;
        if (rx_ok)
            vcnt_d = VW'(VALID_HOLD);
        else if (vcnt_q != '0)
            vcnt_d = vcnt_q - VW'(1);
        valid_d = (vcnt_d != '0);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vcnt_q  <= '0;
            valid_q <= 1'b0;
        end
        else
        begin
            vcnt_q  <= vcnt_d;
            valid_q <= valid_d;
        end
    end

    assign uplink_valid_led = valid_q;

    // ********************************************************************
    // APB registers and interrupt
    // ********************************************************************
    logic [INT_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
    logic [31:0]      rd_q, rd_d;
    logic             wr_acc, hit;

    assign wr_acc = psel && penable && pwrite;

    always_comb
    begin
        hit = (paddr == REG_STATUS) || (paddr == REG_FREQ)
           || (paddr == REG_INT_STAT) || (paddr == REG_INT_MASK)
           || (paddr == REG_FAULT);
        ev = '0;
        ev[INT_OK_POS]   = rx_ok;
        ev[INT_ERR_POS]  = rx_err;
        ev[INT_FLT_POS]  = fault_raw && !fault_q;
        ev[INT_LOST_POS] = valid_q && !valid_d;
        imask_d = imask_q;
        ist_d   = ist_q;
        if (wr_acc && paddr == REG_INT_MASK)
            imask_d = pwdata[INT_W-1:0];
        // A new event wins over a same-cycle clear
        if (wr_acc && paddr == REG_INT_STAT)
            ist_d = ist_q & ~pwdata[INT_W-1:0];
        ist_d = ist_d | ev;
        rd_d = rd_q;
        // Read data is captured in setup so it is a flop in access
        if (psel && !penable && !pwrite)
        begin
            rd_d = 32'h0000_0000;
            unique case (paddr)
                REG_STATUS:
                begin
                    rd_d[ST_VALID_POS]      = valid_q;
                    rd_d[ST_FAULT_POS]      = fault_q;
                    rd_d[ST_MODE_POS +: 2]  = mode;
                    rd_d[ST_RATIO_POS]      = ratio_s;
                end
                REG_FREQ:     rd_d[FREQ_BITS-1:0] = freq_q;
                REG_INT_STAT: rd_d[INT_W-1:0]     = ist_q;
                REG_INT_MASK: rd_d[INT_W-1:0]     = imask_q;
                REG_FAULT:
                begin
                    rd_d[4:0]         = fpin_q;
                    rd_d[CFG_INV_POS] = finv_q;
                end
                default:      rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ist_q   <= '0;
            imask_q <= INT_MASK_RST;
            rd_q    <= '0;
        end
        else
        begin
            ist_q   <= ist_d;
            imask_q <= imask_d;
            rd_q    <= rd_d;
        end
    end

    assign prdata  = rd_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign irq     = |(ist_q & imask_q);

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    word_hold_a: assert property (rx_err |=> freq_q == $past(freq_q))
        else $error("Frequency word changed on a bad frame");
    word_load_a: assert property (rx_ok && kind == KIND_FREQ
        |=> freq_q == $past(rx_data[31:8]))
        else $error("Good frequency frame not loaded");
    low_pins_a: assert property (mode == MODE_LOW_PINS
        |=> pin_out[15:0] == $past(freq_q[15:0]) && &pin_oe[15:0]
            && !pin_oe[24])
        else $error("Low pin mapping wrong");
    high_pins_a: assert property (mode == MODE_HIGH_PINS
        |=> pin_out[24] == $past(freq_q[0]) && pin_out[9] == $past(freq_q[15])
            && !pin_oe[2])
        else $error("High pin mapping wrong");
    scram_pins_a: assert property (mode == MODE_SCRAMBLED
        |=> pin_out[17] == $past(freq_q[0]) && pin_out[23] == $past(freq_q[15])
            && !pin_oe[3])
        else $error("Scrambled pin mapping wrong");
    map_low_a: assert property (mode == MODE_PINMAP && map_q[0] == CODE_GND
        && fpin_q != 5'h0_1 |=> pin_oe[0] && !pin_out[0])
        else $error("Unassigned pin not driven low");
    fault_in_a: assert property (mode == MODE_PINMAP && fpin_q == 5'h0_4
        |=> !pin_oe[3])
        else $error("Fault pin is being driven");
    fault_term_a: assert property (fault_pin == 5'h0_0 |=> !fault_term_out)
        else $error("Fault relay active with no fault pin");
    fault_led_a: assert property (fault_led == fault_term_out)
        else $error("Fault indicator disagrees with relay");
    valid_led_a: assert property (rx_ok |=> uplink_valid_led [*2])
        else $error("Valid indicator missing after good frame");
    irq_err_a: assert property (rx_err && imask_q[INT_ERR_POS]
        |=> irq)
        else $error("Frame error did not raise interrupt");

    map_frame_c: cover property (mode == MODE_PINMAP && rx_ok
        && kind == KIND_MAP);
    bad_frame_c: cover property (rx_err);
    valid_lost_c: cover property (valid_q && !valid_d);
endmodule : uafc_pin_driver

// ### dv/uafc_uplink_model.sv
// Behavioural serial uplink transmitter of the signal processor
`timescale 1ns/10ps
module uafc_uplink_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] bit_clks,
    output logic            line
);
    // Idle high between frames
    initial line = 1'b1;
    task put(input logic b);
        line <= b;
        repeat (bit_clks) @(posedge ref_clk);
    endtask : put
    // ****************************************************************
    // One whole frame on the single line; bad spoils the checksum
    // ****************************************************************
    task send(input logic [3:0] k, input logic [3:0] i,
              input logic [23:0] p, input logic bad);
        logic [39:0] f;
        f = {k, i, p, 8'h00};
        f[7:0] = f[39:32] ^ f[31:24] ^ f[23:16] ^ f[15:8] ^ {7'h0, bad};
        @(posedge ref_clk);
        put(1'b0);
        for (int n = 39; n >= 0; n--)
        begin
            put(f[n]);
        end
        put(1'b1);
    endtask : send
endmodule : uafc_uplink_model

// ### dv/uafc_pin_driver_tb_top.sv
// Self-checking testbench of the uplink pin driver
`timescale 1ns/10ps
module uafc_pin_driver_tb_top;
    import uafc_pkg::*;
    typedef struct packed
    {logic h; logic l; logic [15:0] f; logic flt;} uafc_row_type;
    localparam int MAP [16] = '{18, 19, 6, 7, 21, 22, 23, 11, 10, 9, 20,
                                8, 12, 25, 13, 24};
    uafc_row_type rows [4] = '{'{1, 1, 16'h8001, 1}, '{1, 0, 16'h1234, 0},
                               '{0, 1, 16'hA5C3, 1}, '{0, 1, 16'h5A3C, 0}};
    logic        ref_clk, rst_b, hi, lo, ratio, ft, fled, vled, irq;
    logic        psel, penable, pwrite, pready, pslverr, line, er;
    logic [24:0] pin_in, pin_out, pin_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [49:0] e;
    logic [3:0]  bclk;
    int          n_fail, cmp_count, fp;
    int          cyc = 0;
    uafc_pin_driver #(.VALID_HOLD(50)) i_dut (.ref_clk(ref_clk),
        .rst_b(rst_b), .uplink_in(line), .clock_ratio_jumper(ratio),
        .protocol_select_low_jumper(lo), .protocol_select_high_jumper(hi),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .fault_term_out(ft), .fault_led(fled), .uplink_valid_led(vled),
        .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    uafc_uplink_model i_tx (.ref_clk(ref_clk), .bit_clks(bclk),
        .line(line));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard: ceiling well above the expected run
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            n_fail++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("Mismatches %0d of %0d compares", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // pready is tied high, so this wait ends on the first edge
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task frame(input logic [3:0] k, input logic [3:0] i,
               input logic [23:0] p, input logic bad);
        i_tx.send(k, i, p, bad);
        // Slow bit timing samples the stop bit one edge after it ends
        repeat (4) @(posedge ref_clk);
    endtask : frame
    // ****************************************************************
    // Fixed mappings as rows, then the awkward cases
    // ****************************************************************
    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {hi, lo, ratio, pin_in} = '0;
        bclk = 4'h8;
        n_fail = 0;
        cmp_count = 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b0, REG_INT_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        foreach (rows[r])
        begin
            fp = rows[r].h && rows[r].l ? 24 : rows[r].h ? 2 : 3;
            {hi, lo} <= {rows[r].h, rows[r].l};
            pin_in <= 25'(rows[r].flt) << fp;
            e = '0;
            for (int i = 0; i < 16; i++)
            begin
                fp = rows[r].h && rows[r].l ? i : rows[r].h ? 24 - i
                   : MAP[i] - 1;
                e[fp] = rows[r].f[i];
                e[25 + fp] = 1'b1;
            end
            repeat (4) @(posedge ref_clk);
            frame(KIND_FREQ, 4'h0, {8'h00, rows[r].f}, 1'b0);
            chk({7'h0, pin_out & e[49:25]}, {7'h0, e[24:0]});
            chk({7'h0, pin_oe}, {7'h0, e[49:25]});
            chk({31'h0, ft}, {31'h0, rows[r].flt});
            chk({31'h0, fled}, {31'h0, rows[r].flt});
            chk({31'h0, vled}, 32'h0000_0001);
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            chk(rd & 32'h0000_001C, 32'(r == 0 ? 0 : r == 1 ? 4 : 8));
        end
        apb(1'b1, REG_INT_MASK, 32'h0000_0002);
        apb(1'b1, REG_INT_STAT, 32'h0000_000F);
        frame(KIND_FREQ, 4'h0, 24'h00_FFFF, 1'b1);
        chk({7'h0, pin_out & e[49:25]}, {7'h0, e[24:0]});
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, REG_FREQ, 32'h0000_0000);
        chk(rd, 32'h0000_5A3C);
        apb(1'b1, REG_INT_STAT, 32'h0000_0002);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        repeat (60) @(posedge ref_clk);
        chk({31'h0, vled}, 32'h0000_0000);
        frame(KIND_CFG, 4'h0, 24'h00_0100, 1'b0);
        chk({30'h0, ft, fled}, 32'h0000_0003);
        apb(1'b0, REG_FAULT, 32'h0000_0000);
        chk(rd, 32'h0001_0000);
        frame(KIND_CFG, 4'h0, 24'h00_0000, 1'b0);
        {hi, lo, pin_in} <= '0;
        repeat (4) @(posedge ref_clk);
        chk({7'h0, pin_oe}, 32'h01FF_FFFF);
        chk({7'h0, pin_out}, 32'h0000_0000);
        frame(KIND_MAP, 4'h0, 24'h0E_77C0, 1'b0);
        frame(KIND_MAP, 4'h6, 24'h00_0017, 1'b0);
        frame(KIND_CFG, 4'h0, 24'h00_0003, 1'b0);
        pin_in <= 25'h000_0004;
        frame(KIND_FREQ, 4'h0, 24'h80_0001, 1'b0);
        chk({7'h0, pin_oe}, 32'h01FF_FFF3);
        chk({7'h0, pin_out & 25'h1FF_FFF3}, 32'h0100_0003);
        chk({31'h0, ft}, 32'h0000_0001);
        ratio <= 1'b1;
        bclk <= 4'h6;
        repeat (4) @(posedge ref_clk);
        frame(KIND_FREQ, 4'h0, 24'h80_0000, 1'b0);
        chk({7'h0, pin_out & 25'h1FF_FFF3}, 32'h0100_0002);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_001C, 32'h0000_001C);
        // Mid-run reset: outputs clear at once, pin map back to ground
        rst_b <= 1'b0;
        @(posedge ref_clk);
        chk({7'h0, pin_oe}, 32'h0000_0000);
        chk({30'h0, vled, irq}, 32'h0000_0000);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({7'h0, pin_oe}, 32'h01FF_FFFF);
        chk({7'h0, pin_out}, 32'h0000_0000);
        apb(1'b0, REG_FREQ, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        print_verdict;
    end
endmodule : uafc_pin_driver_tb_top
